/* File: lsq_pkg.sv */
// Constants and types shared by the LED channel sequencer files.
package lsq_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [6:0]  CYC_PER_US_M1 = 7'(CYC_PER_US - 1);

  // Times after the enable rise and the blink stagger spacing, in microseconds.
  localparam int unsigned T_MODE_US     = 47;
  localparam int unsigned T_ACTIVE_US   = 110;
  localparam int unsigned T_STAGGER_US  = 20;
  localparam logic [6:0]  MODE_AT       = 7'(T_MODE_US - 1);
  localparam logic [6:0]  ACTIVE_AT     = 7'(T_ACTIVE_US - 1);
  localparam logic [4:0]  STAGGER_AT    = 5'(T_STAGGER_US - 1);

  // Channel count.
  localparam int unsigned NUM_CH        = 6;

  // Register byte addresses.
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_START_DLY = 8'h04;
  localparam logic [7:0]  ADDR_STEP_DLY  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;

  // Field positions.
  localparam int unsigned CTRL_STYLE_LSB  = 0;
  localparam int unsigned CTRL_UNUSED_LSB = 8;
  localparam int unsigned ST_CHAIN_BIT    = 8;
  localparam int unsigned ST_MODE_BIT     = 9;
  localparam int unsigned ST_SHDN_BIT     = 10;
  localparam int unsigned ST_STATE_LSB    = 12;

  // Reset values.
  localparam logic [1:0]  STYLE_RST     = 2'h0;
  localparam logic [5:0]  UNUSED_RST    = 6'h00;
  localparam logic [15:0] START_DLY_RST = 16'h0064;
  localparam logic [15:0] STEP_DLY_RST  = 16'h0014;

  // Style codes, one per resistor choice.
  localparam logic [1:0]  STYLE_ONE     = 2'h0;
  localparam logic [1:0]  STYLE_TWO     = 2'h1;
  localparam logic [1:0]  STYLE_THREE   = 2'h2;

  typedef enum logic [3:0] {
    ST_OFF,
    ST_WAKE,
    ST_BLINK_RAMP,
    ST_BLINK_HOLD,
    ST_BLINK_FALL,
    ST_SEQ_DELAY,
    ST_SEQ_STEP,
    ST_SEQ_LAST,
    ST_SEQ_HOLD
  } lsq_state_t;

  typedef enum logic [1:0] {
    SEL_CTRL,
    SEL_START_DLY,
    SEL_STEP_DLY,
    SEL_STATUS
  } lsq_sel_t;

endpackage

/* File: lsq_tick_if.sv */
// Interface carrying the microsecond tick between sequencer modules.
`timescale 1ns/1ps
`default_nettype none
interface lsq_tick_if;
  logic us_tick;

  modport src (output us_tick);
  modport snk (input  us_tick);
endinterface
`default_nettype wire

/* File: lsq_tick_div.sv */
// Divider producing a one-cycle pulse every microsecond.
`timescale 1ns/1ps
`default_nettype none
module lsq_tick_div
(
  input  wire logic  clk_in,
  input  wire logic  rst_b_in,
  lsq_tick_if.src    tick
);

  logic [6:0] div_reg;

  // Free-running count; the pulse lasts exactly one clock.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div_reg      <= 7'h00;
      tick.us_tick <= 1'b0;
    end
    else if (div_reg == lsq_pkg::CYC_PER_US_M1)
    begin
      div_reg      <= 7'h00;
      tick.us_tick <= 1'b1;
    end
    else
    begin
      div_reg      <= div_reg + 7'h01;
      tick.us_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: lsq_led_channel_sequencer.sv */
// Six-channel turn-lamp sequencer with an APB register slave.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lsq_led_channel_sequencer
#(
  parameter logic [9:0] US_PER_MS = 10'h03E8
)
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        ENABLE_IN,
  input  wire logic        MODE_SELECT_INPUT_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output var  logic [31:0] PRDATA_OUT,
  output var  logic        PREADY_OUT,
  output var  logic        PSLVERR_OUT,
  output var  logic [5:0]  CHANNEL_OUTPUT_OUT,
  output var  logic        CHAIN_OUTPUT_OUT,
  output var  logic        SHUTDOWN_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Register select from a byte address; valid flag in the top bit.
  function automatic logic [2:0] reg_decode(input logic [7:0] addr);
    case (addr)
      lsq_pkg::ADDR_CTRL:   reg_decode = {1'b1, lsq_pkg::SEL_CTRL};
      lsq_pkg::ADDR_START_DLY: reg_decode = {1'b1, lsq_pkg::SEL_START_DLY};
      lsq_pkg::ADDR_STEP_DLY:  reg_decode = {1'b1, lsq_pkg::SEL_STEP_DLY};
      lsq_pkg::ADDR_STATUS: reg_decode = {1'b1, lsq_pkg::SEL_STATUS};
      default:              reg_decode = 3'h0;
    endcase
  endfunction

  // Channels lit per step for each style code.
  function automatic logic [3:0] group_size(input logic [1:0] style);
    case (style)
      lsq_pkg::STYLE_ONE:   group_size = 4'h1;
      lsq_pkg::STYLE_TWO:   group_size = 4'h2;
      lsq_pkg::STYLE_THREE: group_size = 4'h3;
      default:              group_size = 4'h6;
    endcase
  endfunction

  // Number of used channels below a given channel index.
  function automatic logic [3:0] rank_of(input logic [5:0] used,
                                         input int unsigned idx);
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int unsigned k = 0; k < lsq_pkg::NUM_CH; k++)
    begin
      if (k < idx && used[k])
        cnt = cnt + 4'h1;
    end
    rank_of = cnt;
  endfunction

  // True when a millisecond count has reached its programmed limit.
  function automatic logic timer_done(input logic [15:0] tmr,
                                      input logic [15:0] lim);
    timer_done = ({1'b0, tmr} + 17'h0_0001) >= {1'b0, lim};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  lsq_tick_if            tick_bus ();
  lsq_pkg::lsq_state_t   state_reg;
  logic                  en_prev_reg;
  logic                  mode_reg;
  logic [6:0]            rise_us_reg;
  logic [4:0]            stag_us_reg;
  logic [9:0]            ms_pre_reg;
  logic [15:0]           tmr_reg;
  logic [3:0]            on_count_reg;
  logic [5:0]            lit_reg;
  logic                  chain_reg;
  logic [1:0]            style_reg;
  logic [5:0]            unused_reg;
  logic [15:0]           start_dly_reg;
  logic [15:0]           step_dly_reg;
  logic [5:0]            chan_next;
  logic [5:0]            used;
  logic [3:0]            used_total;
  logic [3:0]            step;
  logic                  en_rise;
  logic                  ms_tick;
  logic                  seq_timed;
  logic                  apb_setup;
  logic                  apb_write;
  logic [2:0]            setup_sel;
  logic [2:0]            access_sel;

  lsq_tick_div u_tick_div
  (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .tick     (tick_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived terms.

  // Unused flags are static straps for the sequencer.
  assign used       = ~unused_reg;
  assign used_total = rank_of(used, lsq_pkg::NUM_CH);
  assign step       = group_size(style_reg);
  assign en_rise    = ENABLE_IN & ~en_prev_reg;
  assign seq_timed  = (state_reg == lsq_pkg::ST_SEQ_DELAY) ||
                      (state_reg == lsq_pkg::ST_SEQ_STEP)  ||
                      (state_reg == lsq_pkg::ST_SEQ_LAST);
  assign ms_tick    = tick_bus.us_tick && (ms_pre_reg == US_PER_MS - 10'h001);

  // Enable edge detector; the pin is taken as synchronous.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      en_prev_reg <= 1'b0;
    else
      en_prev_reg <= ENABLE_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up timing and mode capture.

  // Microseconds since the enable rise, held at the activation point.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      rise_us_reg <= 7'h00;
    else if (state_reg != lsq_pkg::ST_WAKE)
      rise_us_reg <= 7'h00;
    else if (tick_bus.us_tick && rise_us_reg != lsq_pkg::ACTIVE_AT)
      rise_us_reg <= rise_us_reg + 7'h01;
  end

  // Mode is sampled once per on-phase, so later changes wait.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      mode_reg <= 1'b0;
    else if (state_reg == lsq_pkg::ST_WAKE && tick_bus.us_tick &&
             rise_us_reg == lsq_pkg::MODE_AT)
      mode_reg <= MODE_SELECT_INPUT_IN;
  end

  // Millisecond prescaler; idle outside the timed sequence states so
  // every delay starts on a clean millisecond boundary.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      ms_pre_reg <= 10'h000;
    else if (!seq_timed)
      ms_pre_reg <= 10'h000;
    else if (ms_tick)
      ms_pre_reg <= 10'h000;
    else if (tick_bus.us_tick)
      ms_pre_reg <= ms_pre_reg + 10'h001;
  end

  // Stagger spacing counter for the blink ramps.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      stag_us_reg <= 5'h00;
    else if (state_reg != lsq_pkg::ST_BLINK_RAMP &&
             state_reg != lsq_pkg::ST_BLINK_FALL)
      stag_us_reg <= 5'h00;
    else if (tick_bus.us_tick)
      stag_us_reg <= (stag_us_reg == lsq_pkg::STAGGER_AT) ? 5'h00 :
                     stag_us_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine.

  // Any enable drop outside blink mode returns straight to the off
  // state, so each on-phase reruns the pattern from the start.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_reg    <= lsq_pkg::ST_OFF;
      tmr_reg      <= 16'h0000;
      on_count_reg <= 4'h0;
      lit_reg      <= 6'h00;
      chain_reg    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        lsq_pkg::ST_OFF:
        begin
          on_count_reg <= 4'h0;
          lit_reg      <= 6'h00;
          chain_reg    <= 1'b0;
          tmr_reg      <= 16'h0000;
          if (en_rise)
            state_reg <= lsq_pkg::ST_WAKE;
        end
        lsq_pkg::ST_WAKE:
        begin
          if (!ENABLE_IN)
            state_reg <= lsq_pkg::ST_OFF;
          else if (tick_bus.us_tick && rise_us_reg == lsq_pkg::ACTIVE_AT)
          begin
            // Nothing lights before this point.
            if (!mode_reg)
            begin
              lit_reg   <= 6'h01;
              state_reg <= lsq_pkg::ST_BLINK_RAMP;
            end
            else if (start_dly_reg == 16'h0000)
            begin
              on_count_reg <= step;
              state_reg    <= (step >= used_total) ? lsq_pkg::ST_SEQ_LAST :
                              lsq_pkg::ST_SEQ_STEP;
            end
            else
              state_reg <= lsq_pkg::ST_SEQ_DELAY;
          end
        end
        lsq_pkg::ST_BLINK_RAMP:
        begin
          if (!ENABLE_IN)
          begin
            lit_reg   <= lit_reg & (lit_reg - 6'h01);
            state_reg <= lsq_pkg::ST_BLINK_FALL;
          end
          else if (tick_bus.us_tick && stag_us_reg == lsq_pkg::STAGGER_AT)
          begin
            lit_reg <= {lit_reg[4:0], 1'b1};
            if (lit_reg[4])
              state_reg <= lsq_pkg::ST_BLINK_HOLD;
          end
        end
        lsq_pkg::ST_BLINK_HOLD:
        begin
          if (!ENABLE_IN)
          begin
            lit_reg   <= lit_reg & (lit_reg - 6'h01);
            state_reg <= lsq_pkg::ST_BLINK_FALL;
          end
        end
        lsq_pkg::ST_BLINK_FALL:
        begin
          // A new rise abandons the ramp-down and restarts cleanly.
          if (en_rise)
          begin
            lit_reg   <= 6'h00;
            state_reg <= lsq_pkg::ST_WAKE;
          end
          else if (lit_reg == 6'h00)
            state_reg <= lsq_pkg::ST_OFF;
          else if (tick_bus.us_tick && stag_us_reg == lsq_pkg::STAGGER_AT)
            lit_reg <= lit_reg & (lit_reg - 6'h01);
        end
        lsq_pkg::ST_SEQ_DELAY:
        begin
          if (!ENABLE_IN)
            state_reg <= lsq_pkg::ST_OFF;
          else if (ms_tick)
          begin
            if (timer_done(tmr_reg, start_dly_reg))
            begin
              tmr_reg      <= 16'h0000;
              on_count_reg <= step;
              state_reg    <= (step >= used_total) ? lsq_pkg::ST_SEQ_LAST :
                              lsq_pkg::ST_SEQ_STEP;
            end
            else
              tmr_reg <= tmr_reg + 16'h0001;
          end
        end
        lsq_pkg::ST_SEQ_STEP:
        begin
          if (!ENABLE_IN)
            state_reg <= lsq_pkg::ST_OFF;
          else if (ms_tick)
          begin
            if (timer_done(tmr_reg, step_dly_reg))
            begin
              tmr_reg      <= 16'h0000;
              on_count_reg <= on_count_reg + step;
              if (on_count_reg + step >= used_total)
                state_reg <= lsq_pkg::ST_SEQ_LAST;
            end
            else
              tmr_reg <= tmr_reg + 16'h0001;
          end
        end
        lsq_pkg::ST_SEQ_LAST:
        begin
          if (!ENABLE_IN)
            state_reg <= lsq_pkg::ST_OFF;
          else if (ms_tick)
          begin
            if (timer_done(tmr_reg, step_dly_reg))
            begin
              chain_reg <= 1'b1;
              state_reg <= lsq_pkg::ST_SEQ_HOLD;
            end
            else
              tmr_reg <= tmr_reg + 16'h0001;
          end
        end
        lsq_pkg::ST_SEQ_HOLD:
        begin
          if (!ENABLE_IN)
            state_reg <= lsq_pkg::ST_OFF;
        end
        default:
          state_reg <= lsq_pkg::ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel drive.

  // Sequence outputs are gated by the live enable, so a drop turns
  // every channel off at the same edge the state machine sees it.
  generate
    for (genvar i = 0; i < lsq_pkg::NUM_CH; i++)
    begin : g_chan
      always_comb
      begin
        case (state_reg)
          lsq_pkg::ST_BLINK_RAMP,
          lsq_pkg::ST_BLINK_HOLD,
          lsq_pkg::ST_BLINK_FALL:
            chan_next[i] = lit_reg[i] & used[i];
          lsq_pkg::ST_SEQ_STEP,
          lsq_pkg::ST_SEQ_LAST,
          lsq_pkg::ST_SEQ_HOLD:
            chan_next[i] = ENABLE_IN & used[i] &
                           (rank_of(used, i) < on_count_reg);
          default:
            chan_next[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Output flops; chain drops with enable, not one clock later.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      CHANNEL_OUTPUT_OUT <= 6'h00;
      CHAIN_OUTPUT_OUT   <= 1'b0;
      SHUTDOWN_OUT       <= 1'b1;
    end
    else
    begin
      CHANNEL_OUTPUT_OUT <= chan_next;
      CHAIN_OUTPUT_OUT   <= chain_reg & ENABLE_IN;
      SHUTDOWN_OUT       <= (state_reg == lsq_pkg::ST_OFF) & ~ENABLE_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, ready raised by the setup.

  assign apb_setup  = PSEL_IN & ~PENABLE_IN;
  assign apb_write  = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
  assign setup_sel  = reg_decode(PADDR_IN);
  assign access_sel = reg_decode(PADDR_IN);

  // Ready, error and read data are prepared during the setup cycle.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end
    else
    begin
      PREADY_OUT  <= apb_setup;
      PSLVERR_OUT <= apb_setup & ~setup_sel[2];
      if (apb_setup && !PWRITE_IN)
      begin
        PRDATA_OUT <= 32'h0000_0000;
        case (lsq_pkg::lsq_sel_t'(setup_sel[1:0]))
          lsq_pkg::SEL_CTRL:
          begin
            PRDATA_OUT[lsq_pkg::CTRL_STYLE_LSB +: 2]  <= style_reg;
            PRDATA_OUT[lsq_pkg::CTRL_UNUSED_LSB +: 6] <= unused_reg;
          end
          lsq_pkg::SEL_START_DLY: PRDATA_OUT[15:0] <= start_dly_reg;
          lsq_pkg::SEL_STEP_DLY:  PRDATA_OUT[15:0] <= step_dly_reg;
          lsq_pkg::SEL_STATUS:
          begin
            PRDATA_OUT[5:0]                      <= CHANNEL_OUTPUT_OUT;
            PRDATA_OUT[lsq_pkg::ST_CHAIN_BIT]    <= CHAIN_OUTPUT_OUT;
            PRDATA_OUT[lsq_pkg::ST_MODE_BIT]     <= mode_reg;
            PRDATA_OUT[lsq_pkg::ST_SHDN_BIT]     <= SHUTDOWN_OUT;
            PRDATA_OUT[lsq_pkg::ST_STATE_LSB +: 4] <= state_reg;
          end
          default: PRDATA_OUT <= 32'h0000_0000;
        endcase
        if (!setup_sel[2])
          PRDATA_OUT <= 32'h0000_0000;
      end
    end
  end

  // Timing settings arrive as millisecond counts; style arrives as a code.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      style_reg  <= lsq_pkg::STYLE_RST;
      unused_reg <= lsq_pkg::UNUSED_RST;
      start_dly_reg <= lsq_pkg::START_DLY_RST;
      step_dly_reg  <= lsq_pkg::STEP_DLY_RST;
    end
    else if (apb_write && access_sel[2])
    begin
      case (lsq_pkg::lsq_sel_t'(access_sel[1:0]))
        lsq_pkg::SEL_CTRL:
        begin
          style_reg  <= PWDATA_IN[lsq_pkg::CTRL_STYLE_LSB +: 2];
          unused_reg <= PWDATA_IN[lsq_pkg::CTRL_UNUSED_LSB +: 6];
        end
        lsq_pkg::SEL_START_DLY: start_dly_reg <= PWDATA_IN[15:0];
        lsq_pkg::SEL_STEP_DLY:  step_dly_reg  <= PWDATA_IN[15:0];
        default:             style_reg  <= style_reg;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: lsq_seq_assertions.sv */
// Port-level assertion checker for the LED channel sequencer.
`timescale 1ns/1ps
`default_nettype none
module lsq_seq_assertions
(
  input wire logic       CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       ENABLE_IN,
  input wire logic       PSEL_IN,
  input wire logic       PENABLE_IN,
  input wire logic       PREADY_OUT,
  input wire logic       PSLVERR_OUT,
  input wire logic [5:0] CHANNEL_OUTPUT_OUT,
  input wire logic       CHAIN_OUTPUT_OUT,
  input wire logic       SHUTDOWN_OUT
);
  logic [15:0] en_cnt;
  // Cycles since enable rose; saturates so a long phase cannot wrap.
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      en_cnt <= 16'h0000;
    else if (!ENABLE_IN)
      en_cnt <= 16'h0000;
    else if (en_cnt != 16'hFFFF)
      en_cnt <= en_cnt + 16'h0001;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence apb_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence apb_done;
    PSEL_IN && PENABLE_IN && PREADY_OUT;
  endsequence
  // 16'h2A30 is 108 us, a margin below the 110 us start.
  no_early_a: assert property (
    ENABLE_IN && en_cnt < 16'h2A30 && $past(CHANNEL_OUTPUT_OUT) == 6'h00
    |-> CHANNEL_OUTPUT_OUT == 6'h00) else $error("Channel lit too early.");
  dark_low_a: assert property (
    !ENABLE_IN && !$past(ENABLE_IN) && !$past(ENABLE_IN, 2)
    |-> (CHANNEL_OUTPUT_OUT & ~$past(CHANNEL_OUTPUT_OUT)) == 6'h00)
    else $error("Channel turned on while disabled.");
  shdn_dark_a: assert property (
    SHUTDOWN_OUT |-> CHANNEL_OUTPUT_OUT == 6'h00 && !CHAIN_OUTPUT_OUT)
    else $error("Output active in shutdown.");
  wake_up_a: assert property (
    $rose(ENABLE_IN) |-> ##[1:3] !SHUTDOWN_OUT)
    else $error("No wake after enable rise.");
  step_gap_a: assert property (
    $changed(CHANNEL_OUTPUT_OUT) |=> $stable(CHANNEL_OUTPUT_OUT) [*8])
    else $error("Channel steps too close.");
  chain_fall_a: assert property (
    $fell(ENABLE_IN) |-> ##[1:2] !CHAIN_OUTPUT_OUT)
    else $error("Chain output held after enable fall.");
  chain_lit_a: assert property (
    $rose(CHAIN_OUTPUT_OUT) |-> CHANNEL_OUTPUT_OUT != 6'h00
    && $stable(CHANNEL_OUTPUT_OUT)) else $error("Chain rose with step.");
  apb_ready_a: assert property (
    apb_setup |=> PREADY_OUT) else $error("No ready after setup.");
  apb_err_a: assert property (
    PSLVERR_OUT |-> apb_done) else $error("Error outside access.");
endmodule
bind lsq_led_channel_sequencer lsq_seq_assertions chk (.CLK_IN, .RST_B_IN,
  .ENABLE_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .PSLVERR_OUT,
  .CHANNEL_OUTPUT_OUT, .CHAIN_OUTPUT_OUT, .SHUTDOWN_OUT);
`default_nettype wire

/* File: lsq_blink_src.sv */
// Body controller model that drives the blink enable and mode level.
`timescale 1ns/1ps
`default_nettype none
module lsq_blink_src
(
  input  wire logic clk_in,
  output var  logic en_out,
  output var  logic mode_out
);
  // Both lines idle low until a phase is requested.
  initial
  begin
    en_out = 1'b0;
    mode_out = 1'b0;
  end
  // Mode settles a cycle ahead of the rise so the latch sees it.
  task automatic start(input logic mode);
    @(posedge clk_in);
    mode_out <= mode;
    @(posedge clk_in);
    en_out <= 1'b1;
  endtask
  task automatic stop();
    @(posedge clk_in);
    en_out <= 1'b0;
  endtask
  // A mid-phase flip is misuse, issued only when a test asks for it.
  task automatic flip();
    @(posedge clk_in);
    mode_out <= ~mode_out;
  endtask
endmodule
`default_nettype wire

/* File: test_led_channel_sequencer.sv */
// Self-checking testbench for the LED channel sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_led_channel_sequencer;
  logic clk, rst_b, psel, pen, pwr, en, mode, rdy, err, chain, shdn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  ch, um;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t_us, st, gsz, used, lit;
  // Two ticks per millisecond keeps the sequence short.
  lsq_led_channel_sequencer #(.US_PER_MS(10'h0002)) uut (.CLK_IN(clk),
    .RST_B_IN(rst_b), .ENABLE_IN(en), .MODE_SELECT_INPUT_IN(mode),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .CHANNEL_OUTPUT_OUT(ch), .CHAIN_OUTPUT_OUT(chain),
    .SHUTDOWN_OUT(shdn));
  lsq_blink_src body_controller (.clk_in(clk), .en_out(en), .mode_out(mode));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The tests need about 81k cycles; this ceiling cuts a hang.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] eq,
                     input logic ee);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    if (!w)
      chk(prdata, eq);
    chk({31'h0, err}, {31'h0, ee});
    psel <= 1'b0;
    pen <= 1'b0;
    // One idle edge, so a following call never re-drives psel at once.
    @(posedge clk);
  endtask
  // Waits to a time in the phase, then checks chain and channels.
  task automatic at_us(input int us, input logic [5:0] ec, input logic ek);
    repeat ((us - t_us) * 100) @(posedge clk);
    t_us = us;
    chk({25'h0, chain, ch}, {25'h0, ek, ec});
  endtask
  function automatic logic [5:0] lit_mask(input logic [5:0] m, input int n);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++)
      if (!m[i] && n > 0)
      begin
        r[i] = 1'b1;
        n--;
      end
    return r;
  endfunction
  initial
  begin
    {rst_b, psel, pen, pwr, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(0, 8'h00, 32'h0, 32'h0000_0000, 0);
    apb(0, 8'h04, 32'h0, 32'h0000_0064, 0);
    apb(0, 8'h08, 32'h0, 32'h0000_0014, 0);
    apb(0, 8'h10, 32'h0, 32'h0000_0000, 1);
    apb(1, 8'h0C, 32'h0000_FFFF, 32'h0, 0);
    apb(0, 8'h0C, 32'h0, 32'h0000_0400, 0);
    // Blink with channel 2 unused, then a misused mode flip.
    apb(1, 8'h00, 32'h0000_0400, 32'h0, 0);
    body_controller.start(1'b0);
    t_us = 0;
    at_us(100, 6'h00, 0);
    at_us(115, 6'h01, 0);
    at_us(135, 6'h03, 0);
    at_us(215, 6'h3B, 0);
    body_controller.flip();
    at_us(230, 6'h3B, 0);
    apb(0, 8'h0C, 32'h0, 32'h0000_303B, 0);
    body_controller.stop();
    t_us = 0;
    at_us(10, 6'h3A, 0);
    at_us(30, 6'h38, 0);
    at_us(102, 6'h00, 0);
    apb(0, 8'h0C, 32'h0, 32'h0000_0400, 0);
    // Sequential phases, one per style code, interval 1 ms.
    for (int s = 0; s < 4; s++)
    begin
      um = (s == 1) ? 6'h04 : 6'h00;
      st = (s > 1) ? 3 : 0;
      gsz = (s == 3) ? 6 : s + 1;
      used = 6 - $countones(um);
      apb(1, 8'h00, {18'h0, um, 6'h0, 2'(s)}, 32'h0, 0);
      apb(1, 8'h04, 32'(st), 32'h0, 0);
      apb(1, 8'h08, 32'h0000_0001, 32'h0, 0);
      body_controller.start(1'b1);
      t_us = 0;
      at_us(108 + 2 * st, 6'h00, 0);
      lit = 0;
      for (int k = 0; lit < used; k++)
      begin
        lit = (lit + gsz > used) ? used : lit + gsz;
        at_us(111 + 2 * st + 2 * k, lit_mask(um, lit), 0);
      end
      at_us(t_us + 2, lit_mask(um, used), 1);
      apb(0, 8'h0C, 32'h0, {20'h0000_8, 6'h0C, lit_mask(um, used)}, 0);
      body_controller.stop();
      repeat (3) @(posedge clk);
      chk({25'h0, chain, ch}, 32'h0000_0000);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
